/* File: hdl/rtbuf_pkg.sv */
// Constants and types shared by the remote-terminal buffering engine.
package rtbuf_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned AW      = 13;
    localparam int unsigned DW      = 16;
    localparam int unsigned CNT_W   = 10;
    localparam int unsigned WC_W    = 6;

    // ==========================================================
    // Register map (byte offsets) and fields
    localparam logic [7:0]  REG_CFG        = 8'h00;
    localparam logic [7:0]  REG_IEN        = 8'h04;
    localparam logic [7:0]  REG_BASE       = 8'h08;
    localparam logic [7:0]  REG_STAT       = 8'h0c;
    localparam int unsigned CFG_SPLIT      = 0;
    localparam int unsigned IEN_CZ         = 0;
    localparam int unsigned IEN_ACC        = 1;
    localparam int unsigned IEN_BRX        = 2;
    localparam logic [AW-1:0] BASE_RST     = 13'h0000;
    localparam logic [2:0]  IEN_RST        = 3'h0;

    // ==========================================================
    // Descriptor control word bits and descriptor word slots
    localparam int unsigned CTL_CZ   = 15;
    localparam int unsigned CTL_ACC  = 14;
    localparam int unsigned CTL_BRX  = 13;
    localparam int unsigned CTL_ALT  = 12;
    localparam int unsigned CTL_R2   = 11;
    localparam int unsigned CTL_R1   = 10;
    localparam logic [1:0]  DW_CTL   = 2'd0;
    localparam logic [1:0]  DW_PTR   = 2'd1;
    localparam logic [1:0]  DW_CNT   = 2'd2;
    localparam logic [1:0]  DW_AUX   = 2'd3;

    // ==========================================================
    // Command word fields and record layout
    localparam int unsigned CMD_TR     = 10;
    localparam int unsigned CMD_SA_LSB = 5;
    localparam logic [4:0]  SA_MODE_LO = 5'h00;
    localparam logic [4:0]  SA_MODE_HI = 5'h1f;
    localparam int unsigned MIW_BROADCAST_FLAG  = 9;
    localparam logic [AW-1:0] DATA_OFS = 13'h0002;
    localparam logic [AW-1:0] TT_OFS   = 13'h0001;
    localparam logic [WC_W-1:0] WC_MAX = 6'h20;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DESC = 2'b01,
        ST_XFER = 2'b10,
        ST_POST = 2'b11
    } eng_state_t;
endpackage

/* File: hdl/rtbuf_regs.sv */
// AHB-Lite register slave for the buffering engine.
`timescale 1ns/100ps
module rtbuf_regs
    import rtbuf_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    output logic               split_en,
    output logic [2:0]         int_en,
    output logic [AW-1:0]      desc_base,
    input  wire logic [31:0]   status
);
    // ==========================================================
    // Decode
    logic          wr_pend_ff;
    logic [7:0]    wr_addr_ff;
    logic [31:0]   hrdata_ff;
    logic          split_ff;
    logic [2:0]    ien_ff;
    logic [AW-1:0] base_ff;

    wire        take    = hsel & hready & htrans[1];
    wire [31:0] rd_mux  = (haddr[7:0] == REG_CFG)  ? {31'h0, split_ff} :
                          (haddr[7:0] == REG_IEN)  ? {29'h0, ien_ff} :
                          (haddr[7:0] == REG_BASE) ? {19'h0, base_ff} :
                          (haddr[7:0] == REG_STAT) ? status : 32'h0000_0000;
    wire        wr_cfg  = wr_pend_ff & (wr_addr_ff == REG_CFG);
    wire        wr_ien  = wr_pend_ff & (wr_addr_ff == REG_IEN);
    wire        wr_base = wr_pend_ff & (wr_addr_ff == REG_BASE);

    // ==========================================================
    // Registers. Zero wait states, so hreadyout never drops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h0000_0000;
            split_ff   <= 1'b0;
            ien_ff     <= IEN_RST;
            base_ff    <= BASE_RST;
        end else begin
            wr_pend_ff <= take & hwrite;
            wr_addr_ff <= haddr[7:0];
            hrdata_ff  <= (take & ~hwrite) ? rd_mux : 32'h0000_0000;
            if (wr_cfg) begin
                split_ff <= hwdata[CFG_SPLIT];
            end
            if (wr_ien) begin
                ien_ff <= hwdata[2:0];
            end
            if (wr_base) begin
                base_ff <= hwdata[AW-1:0];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign split_en  = split_ff;
    assign int_en    = ien_ff;
    assign desc_base = base_ff;
endmodule

/* File: hdl/rt_buffer_engine.sv */
// Descriptor-driven message buffering engine for a remote terminal.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module rt_buffer_engine
    import rtbuf_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    input  wire logic          cmd_valid,
    input  wire logic [DW-1:0] cmd_word,
    input  wire logic          cmd_broadcast_flag,
    output logic               busy,
    input  wire logic          rx_valid,
    input  wire logic [DW-1:0] rx_data,
    input  wire logic          tx_req,
    output logic               tx_valid,
    output logic [DW-1:0]      tx_data,
    input  wire logic          msg_end,
    input  wire logic          msg_error,
    input  wire logic          msg_illegal,
    input  wire logic [DW-1:0] msg_info,
    input  wire logic [DW-1:0] msg_ttag,
    output logic               ram_en,
    output logic               ram_we,
    output logic [AW-1:0]      ram_addr,
    output logic [DW-1:0]      ram_wdata,
    input  wire logic [DW-1:0] ram_rdata,
    output logic               host_int
);
    // ==========================================================
    // State
    eng_state_t    state_ff, nxt_state;
    logic [2:0]    dcnt_ff, nxt_dcnt;
    logic [1:0]    pcnt_ff, nxt_pcnt;
    logic [WC_W-1:0] wcnt_ff, nxt_wcnt;
    logic [AW-1:0] dbase_ff;
    logic [DW-1:0] desc_ff [0:3];
    logic          tr_ff, bc_ff, mode_ff, err_ff, ill_ff;
    logic [DW-1:0] info_ff, ttag_ff;
    logic [1:0]    tx_pipe_ff;
    logic          tx_valid_ff;
    logic [DW-1:0] tx_data_ff;
    logic          ram_en_ff, nxt_ram_en;
    logic          ram_we_ff, nxt_ram_we;
    logic [AW-1:0] ram_addr_ff, nxt_ram_addr;
    logic [DW-1:0] ram_wdata_ff, nxt_ram_wdata;
    logic          tx_issue;
    logic          int_ff, nxt_int;
    logic          busy_ff;
    logic [2:0]    last_ev_ff;
    logic [15:0]   msgs_ff;
    logic          split_en;
    logic [2:0]    int_en;
    logic [AW-1:0] desc_base;

    // ==========================================================
    // Register slave
    wire [31:0] status = {msgs_ff, 12'h000, last_ev_ff, busy_ff};

    rtbuf_regs u_regs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .split_en  (split_en),
        .int_en    (int_en),
        .desc_base (desc_base),
        .status    (status)
    );

    // ==========================================================
    // Descriptor selection
    wire [4:0]    sa_fld  = cmd_word[CMD_SA_LSB +: 5];
    wire          is_mode = (sa_fld == SA_MODE_LO) | (sa_fld == SA_MODE_HI);
    wire [4:0]    sub_fld = is_mode ? cmd_word[4:0] : sa_fld;
    wire [6:0]    didx    = {is_mode, cmd_word[CMD_TR], sub_fld};
    wire [AW-1:0] daddr   = desc_base + {4'h0, didx, 2'b00};

    // ==========================================================
    // Mode decode and buffer addressing
    wire [DW-1:0] ctl     = desc_ff[DW_CTL];
    wire          no_alt  = ~ctl[CTL_ALT] & ~ctl[CTL_R2];
    wire          ring1   = no_alt & ctl[CTL_R1] & ~mode_ff;
    wire          indexed = no_alt & ~ctl[CTL_R1];
    // Broadcast buffer is trusted to be valid when split is on.
    wire          use_bc  = split_en & bc_ff & indexed;
    wire [AW-1:0] start_p = desc_ff[DW_PTR][AW-1:0];
    wire [AW-1:0] end_p   = desc_ff[DW_AUX][AW-1:0];
    wire [AW-1:0] buf_base = ring1  ? desc_ff[DW_CNT][AW-1:0] :
                             use_bc ? end_p : start_p;
    wire [AW-1:0] next_addr = buf_base + DATA_OFS + {7'h00, wcnt_ff};
    wire [AW-1:0] tt_addr  = buf_base + TT_OFS;

    // ==========================================================
    // Post-processing decisions
    wire [CNT_W-1:0] cnt     = desc_ff[DW_CNT][CNT_W-1:0];
    wire [CNT_W-1:0] new_cnt = cnt - 10'd1;
    wire          bad     = err_ff | ill_ff;
    wire          dec     = indexed & ~bad & (cnt != 10'd0) & ~use_bc;
    wire          ptr_upd = dec & (new_cnt != 10'd0);
    // Writes may run past the end pointer; the host keeps a pad there.
    wire          wrap    = next_addr >= end_p;
    wire [AW-1:0] new_cur = wrap ? start_p : next_addr;
    wire          r_upd   = ring1 & ~bad & ~(bc_ff & tr_ff);
    wire          ev_cz   = ctl[CTL_CZ] & ((dec & (new_cnt == 10'd0)) | (r_upd & wrap));
    wire          ev_acc  = ctl[CTL_ACC];
    wire          ev_brx  = ctl[CTL_BRX] & bc_ff;
    wire [2:0]    events  = {ev_brx, ev_acc, ev_cz};
    wire          irq     = |(events & {int_en[IEN_BRX], int_en[IEN_ACC], int_en[IEN_CZ]});
    wire [DW-1:0] miw     = info_ff | (16'(bc_ff) << MIW_BROADCAST_FLAG);
    wire [DW-1:0] cnt_word = {desc_ff[DW_CNT][DW-1:CNT_W], new_cnt};
    wire          wc_room = wcnt_ff != WC_MAX;

    // ==========================================================
    // Sequencer
    always_comb begin
        nxt_state     = state_ff;
        nxt_dcnt      = dcnt_ff;
        nxt_pcnt      = pcnt_ff;
        nxt_wcnt      = wcnt_ff;
        nxt_ram_en    = 1'b0;
        nxt_ram_we    = 1'b0;
        nxt_ram_addr  = ram_addr_ff;
        nxt_ram_wdata = ram_wdata_ff;
        nxt_int       = 1'b0;
        tx_issue      = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_dcnt = 3'd0;
                nxt_wcnt = '0;
                nxt_pcnt = 2'd0;
                if (cmd_valid) begin
                    nxt_state = ST_DESC;
                end
            end
            ST_DESC: begin
                nxt_dcnt = dcnt_ff + 3'd1;
                if (dcnt_ff < 3'd4) begin
                    nxt_ram_en   = 1'b1;
                    nxt_ram_addr = dbase_ff + {10'h000, dcnt_ff};
                end
                if (dcnt_ff == 3'd5) begin
                    nxt_state = (ring1 | indexed) ? ST_XFER : ST_IDLE;
                end
            end
            ST_XFER: begin
                if (msg_end) begin
                    nxt_state = ST_POST;
                end else if (rx_valid & ~tr_ff & wc_room) begin
                    nxt_ram_en    = 1'b1;
                    nxt_ram_we    = 1'b1;
                    nxt_ram_addr  = next_addr;
                    nxt_ram_wdata = rx_data;
                    nxt_wcnt      = wcnt_ff + 6'd1;
                end else if (tx_req & tr_ff & wc_room) begin
                    nxt_ram_en   = 1'b1;
                    nxt_ram_addr = next_addr;
                    nxt_wcnt     = wcnt_ff + 6'd1;
                    tx_issue     = 1'b1;
                end
            end
            ST_POST: begin
                nxt_pcnt = pcnt_ff + 2'd1;
                case (pcnt_ff)
                    2'd0: begin
                        nxt_ram_en    = 1'b1;
                        nxt_ram_we    = 1'b1;
                        nxt_ram_addr  = buf_base;
                        nxt_ram_wdata = miw;
                    end
                    2'd1: begin
                        nxt_ram_en    = 1'b1;
                        nxt_ram_we    = 1'b1;
                        nxt_ram_addr  = tt_addr;
                        nxt_ram_wdata = ttag_ff;
                    end
                    2'd2: begin
                        nxt_ram_en    = dec | r_upd;
                        nxt_ram_we    = dec | r_upd;
                        nxt_ram_addr  = dbase_ff + {11'h000, DW_CNT};
                        nxt_ram_wdata = ring1 ? {3'h0, new_cur} : cnt_word;
                    end
                    default: begin
                        nxt_ram_en    = ptr_upd;
                        nxt_ram_we    = ptr_upd;
                        nxt_ram_addr  = dbase_ff + {11'h000, DW_PTR};
                        nxt_ram_wdata = {3'h0, next_addr};
                        nxt_int       = irq;
                        nxt_state     = ST_IDLE;
                    end
                endcase
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff     <= ST_IDLE;
            dcnt_ff      <= 3'd0;
            pcnt_ff      <= 2'd0;
            wcnt_ff      <= '0;
            ram_en_ff    <= 1'b0;
            ram_we_ff    <= 1'b0;
            ram_addr_ff  <= '0;
            ram_wdata_ff <= '0;
            int_ff       <= 1'b0;
            busy_ff      <= 1'b0;
            tx_pipe_ff   <= 2'b00;
        end else begin
            state_ff     <= nxt_state;
            dcnt_ff      <= nxt_dcnt;
            pcnt_ff      <= nxt_pcnt;
            wcnt_ff      <= nxt_wcnt;
            ram_en_ff    <= nxt_ram_en;
            ram_we_ff    <= nxt_ram_we;
            ram_addr_ff  <= nxt_ram_addr;
            ram_wdata_ff <= nxt_ram_wdata;
            int_ff       <= nxt_int;
            busy_ff      <= nxt_state != ST_IDLE;
            tx_pipe_ff   <= {tx_pipe_ff[0], tx_issue};
        end
    end

    // Command and message context.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbase_ff <= '0;
            tr_ff    <= 1'b0;
            bc_ff    <= 1'b0;
            mode_ff  <= 1'b0;
            err_ff   <= 1'b0;
            ill_ff   <= 1'b0;
            info_ff  <= '0;
            ttag_ff  <= '0;
        end else begin
            if (state_ff == ST_IDLE && cmd_valid) begin
                dbase_ff <= daddr;
                tr_ff    <= cmd_word[CMD_TR];
                bc_ff    <= cmd_broadcast_flag;
                mode_ff  <= is_mode;
            end
            if (state_ff == ST_XFER && msg_end) begin
                err_ff  <= msg_error;
                ill_ff  <= msg_illegal;
                info_ff <= msg_info;
                ttag_ff <= msg_ttag;
            end
        end
    end

    // Descriptor words arrive two cycles after their read is decided.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                desc_ff[i] <= '0;
            end
        end else if (state_ff == ST_DESC && dcnt_ff >= 3'd2) begin
            desc_ff[dcnt_ff[1:0] - 2'd2] <= ram_rdata;
        end
    end

    // Transmit data and status.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= '0;
            last_ev_ff  <= 3'h0;
            msgs_ff     <= 16'h0000;
        end else begin
            tx_valid_ff <= tx_pipe_ff[1];
            if (tx_pipe_ff[1]) begin
                tx_data_ff <= ram_rdata;
            end
            if (state_ff == ST_POST && pcnt_ff == 2'd3) begin
                last_ev_ff <= events;
                msgs_ff    <= msgs_ff + 16'h0001;
            end
        end
    end

    assign busy      = busy_ff;
    assign tx_valid  = tx_valid_ff;
    assign tx_data   = tx_data_ff;
    assign ram_en    = ram_en_ff;
    assign ram_we    = ram_we_ff;
    assign ram_addr  = ram_addr_ff;
    assign ram_wdata = ram_wdata_ff;
    assign host_int  = int_ff;
endmodule

/* File: dv/rt_ram_model.sv */
// Synchronous shared message memory standing at the far side of the engine.
`timescale 1ns/100ps
module rt_ram_model
    import rtbuf_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          ram_en,
    input  wire logic          ram_we,
    input  wire logic [AW-1:0] ram_addr,
    input  wire logic [DW-1:0] ram_wdata,
    output logic      [DW-1:0] ram_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    // ==========================================================
    // Storage
    // Idle cycles invert the read port, so a stale word reads back inverted only after an odd number of them.
    always @(posedge hclk) begin
        if (ram_en && ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
        ram_rdata <= ram_en ? mem[ram_addr] : ~ram_rdata;
    end
endmodule

/* File: dv/rt_buffer_checker.sv */
// Port timing checker for the buffering engine.
`timescale 1ns/100ps
module rt_buffer_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        cmd_valid,
    input wire logic        busy,
    input wire logic        tx_req,
    input wire logic        tx_valid,
    input wire logic        msg_end,
    input wire logic        ram_en,
    input wire logic        ram_we,
    input wire logic        host_int
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Properties
    desc_read_a: assert property (cmd_valid && !busy |=> busy ##1 (ram_en && !ram_we)[*4])
        else $error("descriptor read sequence missing");
    info_first_a: assert property (msg_end && busy |=> ##1 ram_en && ram_we)
        else $error("no record write after message end");
    end_bound_a: assert property (msg_end && busy |-> ##[1:8] !busy)
        else $error("post-processing too long");
    int_pulse_a: assert property (host_int |=> !host_int)
        else $error("interrupt longer than one cycle");
    int_done_a: assert property (host_int |-> ##[0:1] !busy)
        else $error("interrupt not at end of processing");
    tx_lat_a: assert property ($rose(tx_valid) |-> $past(tx_req, 3))
        else $error("transmit word without request");
    tx_pulse_a: assert property (tx_valid |=> !tx_valid)
        else $error("transmit valid longer than one cycle");
    idle_quiet_a: assert property (!busy && !$past(busy) |-> !ram_en)
        else $error("memory access while idle");
    rdata_phase_a: assert property (hrdata != 32'h0 |-> $past(hsel && hready && htrans[1] && !hwrite))
        else $error("read data outside a read data phase");
endmodule
bind rt_buffer_engine rt_buffer_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .cmd_valid(cmd_valid), .busy(busy), .tx_req(tx_req),
    .tx_valid(tx_valid), .msg_end(msg_end), .ram_en(ram_en), .ram_we(ram_we),
    .host_int(host_int)
);

/* File: dv/rt_buffer_engine_tb.sv */
// Self-checking bench for the buffering engine.
`timescale 1ns/100ps
module rt_buffer_engine_tb;
    import rtbuf_pkg::*;
    localparam logic [AW-1:0] DB = 13'h0100;
    logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cmd_valid = 1'b0;
    logic          cmd_broadcast_flag = 1'b0, rx_valid = 1'b0, tx_req = 1'b0, msg_end = 1'b0;
    logic          msg_error = 1'b0, msg_illegal = 1'b0, split = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [2:0]    hsize = 3'h2, ien = 3'h0;
    logic [31:0]   haddr = 32'h0, hwdata = 32'h0, rd;
    logic [15:0]   cmd_word = 16'h0, rx_data = 16'h0, msg_info = 16'h0, msg_ttag = 16'h0;
    logic [15:0]   lf = 16'h0057;
    logic          hreadyout, hresp, busy, tx_valid, ram_en, ram_we, host_int;
    logic [31:0]   hrdata;
    logic [15:0]   tx_data, ram_wdata, ram_rdata;
    logic [AW-1:0] ram_addr;
    int            num_errors = 0, comparisons = 0, cyc = 0, nint = 0, nmsg = 0;
    // ==========================================================
    // Design and memory
    rt_buffer_engine u_rt_buffer_engine (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .cmd_broadcast_flag(cmd_broadcast_flag), .busy(busy), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
        .msg_end(msg_end), .msg_error(msg_error), .msg_illegal(msg_illegal),
        .msg_info(msg_info), .msg_ttag(msg_ttag), .ram_en(ram_en), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .host_int(host_int)
    );
    rt_ram_model u_ram (
        .hclk(hclk), .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr),
        .ram_wdata(ram_wdata), .ram_rdata(ram_rdata)
    );
    always #2.5 hclk = ~hclk;
    // A hang anywhere ends the run through the same verdict.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (host_int === 1'b1) nint <= nint + 1;
        if (cyc == 5000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // Helpers
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int da(input logic tr, input logic [4:0] sa, wc);
        logic md;
        md = (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
        return DB + 4 * {md, tr, md ? wc : sa};
    endfunction
    task automatic chk(input string nm, input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic cfg(input logic s, input logic [2:0] e);
        split = s;
        ien = e;
        ahb(1'b1, REG_CFG, {31'h0, s});
        ahb(1'b1, REG_IEN, {29'h0, e});
    endtask
    task automatic desc(input logic tr, input logic [4:0] sa, wc, input logic [15:0] c, p, n, e);
        int a;
        a = da(tr, sa, wc);
        u_ram.mem[a] = c;
        u_ram.mem[a + 1] = p;
        u_ram.mem[a + 2] = n;
        u_ram.mem[a + 3] = e;
    endtask
    // Runs one message and compares the record, pointers and interrupts with the model.
    task automatic msg(input logic tr, input logic [4:0] sa, wc, input logic bc, input int n,
                       input logic [1:0] bad);
        int a, b, i0;
        logic [15:0] c, p1, p2, p3, inf, tt, e1, e2, nxa;
        logic md, rf, ring, ok, up, cz;
        logic [15:0] q[$];
        a = da(tr, sa, wc);
        c = u_ram.mem[a];
        p1 = u_ram.mem[a + 1];
        p2 = u_ram.mem[a + 2];
        p3 = u_ram.mem[a + 3];
        md = (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
        rf = c[CTL_ALT] || c[CTL_R2] || (c[CTL_R1] && md);
        ring = c[CTL_R1] && !rf;
        b = ring ? p2 : (split && bc) ? p3 : p1;
        i0 = nint;
        if (!rf) nmsg++;
        lf = nx(lf);
        inf = lf & 16'hfdff;
        tt = ~lf;
        cmd_valid <= 1'b1;
        cmd_word <= {5'h0, tr, sa, wc};
        cmd_broadcast_flag <= bc;
        @(posedge hclk);
        cmd_valid <= 1'b0;
        repeat (8) @(posedge hclk);
        for (int k = 0; k < n; k++) begin
            lf = nx(lf);
            q.push_back(lf);
            rx_valid <= !tr;
            rx_data <= lf;
            tx_req <= tr;
            @(posedge hclk);
            tx_req <= 1'b0;
            for (int w = 0; tr && w < 6 && tx_valid !== 1'b1; w++) @(posedge hclk);
            if (tr) chk("tx_data", tx_data, u_ram.mem[b + 2 + k]);
        end
        rx_valid <= 1'b0;
        msg_end <= 1'b1;
        msg_error <= bad[0];
        msg_illegal <= bad[1];
        msg_info <= inf;
        msg_ttag <= tt;
        @(posedge hclk);
        msg_end <= 1'b0;
        for (int w = 0; w < 40 && busy !== 1'b0; w++) @(posedge hclk);
        repeat (3) @(posedge hclk);
        ok = (bad == 2'b00);
        nxa = 16'(b + 2 + n);
        if (ring) begin
            up = ok && !(bc && tr);
            cz = up && (nxa >= p3);
            e2 = !up ? p2 : cz ? p1 : nxa;
            e1 = p1;
        end else begin
            up = ok && !rf && p2[9:0] != 10'h0 && !(split && bc);
            cz = up && p2[9:0] == 10'h1;
            e2 = up ? p2 - 16'h1 : p2;
            e1 = (up && !cz) ? nxa : p1;
        end
        chk("ptr", u_ram.mem[a + 1], e1);
        chk("cur", u_ram.mem[a + 2], e2);
        chk("end", u_ram.mem[a + 3], p3);
        chk("ints", nint - i0, !rf && ((c[CTL_CZ] && cz && ien[IEN_CZ]) || (c[CTL_ACC] &&
            ien[IEN_ACC]) || (c[CTL_BRX] && bc && ien[IEN_BRX])));
        if (!rf) chk("info", u_ram.mem[b], inf | {6'h0, bc, 9'h0});
        if (!rf) chk("ttag", u_ram.mem[b + 1], tt);
        for (int k = 0; k < n && ok && !tr && !rf; k++) chk("data", u_ram.mem[b + 2 + k], q[k]);
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b1, REG_BASE, {19'h0, DB});
        ahb(1'b0, REG_BASE, 32'h0);
        chk("base", rd, {19'h0, DB});
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        cfg(1'b0, 3'b011);
        desc(0, 5'd3, 5'd2, 16'hc000, 16'h0200, 16'h0002, 16'h0300);
        repeat (3) msg(0, 5'd3, 5'd2, 0, 2, 2'b00);
        desc(0, 5'd4, 5'd1, 16'h4000, 16'h0240, 16'h0005, 16'h0300);
        msg(0, 5'd4, 5'd1, 0, 1, 2'b01);
        msg(0, 5'd4, 5'd1, 0, 1, 2'b10);
        cfg(1'b0, 3'b100);
        desc(0, 5'd5, 5'd3, 16'h2000, 16'h0280, 16'h0003, 16'h02c0);
        msg(0, 5'd5, 5'd3, 1, 3, 2'b00);
        cfg(1'b1, 3'b100);
        msg(0, 5'd5, 5'd3, 1, 3, 2'b00);
        msg(0, 5'd5, 5'd3, 0, 3, 2'b00);
        cfg(1'b1, 3'b011);
        msg(0, 5'd5, 5'd3, 1, 3, 2'b00);
        desc(0, 5'd7, 5'd4, 16'h8400, 16'h0400, 16'h0400, 16'h040a);
        msg(0, 5'd7, 5'd4, 0, 4, 2'b00);
        msg(0, 5'd7, 5'd2, 1, 2, 2'b00);
        for (int i = 2; i < 16; i++) begin
            lf = nx(lf);
            u_ram.mem[13'h0500 + i] = lf;
        end
        desc(1, 5'd7, 5'd3, 16'h0400, 16'h0500, 16'h0500, 16'h0520);
        msg(1, 5'd7, 5'd3, 0, 3, 2'b00);
        msg(1, 5'd7, 5'd2, 1, 0, 2'b00);
        msg(1, 5'd7, 5'd2, 0, 2, 2'b00);
        desc(0, 5'd0, 5'd2, 16'h4400, 16'h0600, 16'h0600, 16'h0620);
        msg(0, 5'd0, 5'd2, 0, 2, 2'b00);
        desc(0, 5'd9, 5'd2, 16'h4c00, 16'h0600, 16'h0600, 16'h0620);
        msg(0, 5'd9, 5'd2, 0, 2, 2'b00);
        ahb(1'b0, REG_STAT, 32'h0);
        chk("status", rd, {nmsg[15:0], 16'h0000});
        give_verdict();
    end
endmodule
